// *** hlt_consts.svh ***
`ifndef HLT_CONSTS_SVH
`define HLT_CONSTS_SVH

// Register word indices; byte address is four times the index
`define HLT_IDX_CTRL      3'h0
`define HLT_IDX_PERIOD    3'h1
`define HLT_IDX_PULSE     3'h2
`define HLT_IDX_COUNT     3'h3
`define HLT_IDX_STATUS    3'h4

// Control register layout
`define HLT_CTRL_RUN_BIT  7
`define HLT_CTRL_MODE_MSB 4
`define HLT_CTRL_MODE_LSB 0

// Status register layout
`define HLT_STAT_PWM_BIT  0
`define HLT_STAT_GO_BIT   1
`define HLT_STAT_HOLD_BIT 2
`define HLT_STAT_RUN_BIT  3
`define HLT_STAT_WAIT_BIT 4

// Reset values
`define HLT_RST_MODE      5'h00
`define HLT_RST_PERIOD    8'hFF
`define HLT_RST_PULSE     8'h00
`define HLT_RST_COUNT     8'h00
`define HLT_RST_DATA      32'h0000_0000

// Mode codes
`define HLT_MODE_GATE_SW  5'h00
`define HLT_MODE_EDGE_ANY 5'h03
`define HLT_MODE_EDGE_RIS 5'h04
`define HLT_MODE_EDGE_FAL 5'h05
`define HLT_MODE_LVL_LOW  5'h06
`define HLT_MODE_LVL_HIGH 5'h07
`define HLT_MODE_OS_SW    5'h08
`define HLT_MODE_OS_RIS   5'h09
`define HLT_MODE_OS_FAL   5'h0A
`define HLT_MODE_OS_ANY   5'h0B

// Timing in timer clocks
`define HLT_RST_DLY       2'h2
`define HLT_CNT_ONE       8'h01
`define HLT_CNT_ZERO      8'h00
`define HLT_DLY_ZERO      2'h0
`define HLT_DLY_ONE       2'h1

`endif

// *** hlt_ers_model.sv ***
module hlt_ers_model (
  input  wire logic mclk_i,
  input  wire logic want_i,
  output logic      ers_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Source is a plain logic level, moved only after a timer edge
  initial ers_o = 1'b0;
  always @(posedge mclk_i) ers_o <= want_i;
endmodule

// *** hlt_if.sv ***
interface hlt_if
  import hlt_pkg::*;
;
  hlt_byte_t count;
  hlt_byte_t pulse_width;
  logic      start;
  logic      pwm;

  modport tmr (output count, output pulse_width, output start, input pwm);
  modport drv (input count, input pulse_width, input start, output pwm);
endinterface

// *** hlt_pkg.sv ***
package hlt_pkg;

  typedef logic [7:0] hlt_byte_t;
  typedef logic [4:0] hlt_mode_t;

  // Behaviour class that a mode code selects
  typedef enum logic [2:0] {
    CLS_FREE,
    CLS_EDGE_HL,
    CLS_LEVEL_HL,
    CLS_OS_SW,
    CLS_OS_EDGE
  } hlt_cls_e;

endpackage

// *** hlt_pwm.sv ***
module hlt_pwm
  import hlt_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  hlt_if.drv        bus
);

  logic pwm_reg;

  // Start wins so a zero pulse width still gives one clock of drive
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_reg <= 1'b0;
    end else if (bus.start) begin
      pwm_reg <= 1'b1;
    end else if (bus.count == bus.pulse_width) begin
      pwm_reg <= 1'b0;
    end
  end

  assign bus.pwm = pwm_reg;

endmodule

// *** hlt_sync.sv ***
module hlt_sync (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// *** hlt_timer.sv ***
// Function
// - Edge hardware limit clears count on edge
// - Early edge restarts PWM after two clocks
// - Level hardware limit resets on chosen level
// - Level mode ignores reset input when stopped
// - Level mode: PWM high at start, low at match
// - Level reset: period match or two active clocks
// - Resume after match or two clocks after release
// - Held PWM stays high through level reset
// - Software one-shot: match clears count and run
// - Software one-shot: run bit pauses and resumes
// - Software one-shot: PWM from run set to match
// - Pausing stretches the active PWM drive
// - Edge one-shot starts on edge, stops at match
// - Edge one-shot needs fresh edge after pause
// - Starting edge activates PWM, not period match
// - Run bit synchronised before affecting count
// - Count increments, wraps to zero after match
// - One-shot match clears run, stops at zero
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`include "hlt_consts.svh"

module hlt_timer
  import hlt_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        external_reset_input_i,
  output logic             pwm_o
);

  hlt_if u_if ();

  logic      run_reg;
  hlt_mode_t mode_reg;
  hlt_byte_t period_value_reg;
  hlt_byte_t pulse_width_value_reg;
  hlt_byte_t count_value_reg;
  hlt_byte_t count_value_next;
  logic      go_reg;
  logic      go_next;
  logic      hold_reg;
  logic      hold_next;
  logic      wait_low_reg;
  logic      wait_low_next;
  logic      run_d_reg;
  logic      ers_d_reg;
  logic [1:0] act_cnt_reg;
  logic [1:0] act_cnt_next;
  logic [1:0] dly_reg;
  logic [1:0] dly_next;
  logic      run_s;
  logic      ers_s;
  logic      ers_rise;
  logic      ers_fall;
  logic      run_rise;
  logic      per_match;
  logic      edge_hit;
  logic      lvl_act;
  logic      start;
  logic      clr_run;
  hlt_cls_e  cls;
  logic      wait_reg;
  logic      req;
  logic      commit;
  logic      wr_lane0;
  logic [2:0] idx;
  logic [31:0] rd_next;

  // Run bit and external input crossed in before use
  hlt_sync u_run_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (run_reg),
    .q_o     (run_s)
  );

  hlt_sync u_ers_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (external_reset_input_i),
    .q_o     (ers_s)
  );

  hlt_pwm u_pwm (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .bus     (u_if.drv)
  );

  assign u_if.count       = count_value_reg;
  assign u_if.pulse_width = pulse_width_value_reg;
  assign u_if.start       = start;
  assign pwm_o            = u_if.pwm;

  // Avalon slave: one wait state, commit when waitrequest is low
  assign req      = avs_read_i | avs_write_i;
  assign commit   = req & ~wait_reg;
  assign wr_lane0 = commit & avs_write_i & avs_byteenable_i[0];
  assign idx      = avs_address_i[4:2];
  assign avs_waitrequest_o = wait_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
    end else if (req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always_comb begin
    rd_next = `HLT_RST_DATA;
    unique case (idx)
      `HLT_IDX_CTRL: begin
        rd_next[`HLT_CTRL_RUN_BIT] = run_reg;
        rd_next[`HLT_CTRL_MODE_MSB:`HLT_CTRL_MODE_LSB] = mode_reg;
      end
      `HLT_IDX_PERIOD: rd_next[7:0] = period_value_reg;
      `HLT_IDX_PULSE:  rd_next[7:0] = pulse_width_value_reg;
      `HLT_IDX_COUNT:  rd_next[7:0] = count_value_reg;
      `HLT_IDX_STATUS: begin
        rd_next[`HLT_STAT_PWM_BIT]  = u_if.pwm;
        rd_next[`HLT_STAT_GO_BIT]   = go_reg;
        rd_next[`HLT_STAT_HOLD_BIT] = hold_reg;
        rd_next[`HLT_STAT_RUN_BIT]  = run_s;
        rd_next[`HLT_STAT_WAIT_BIT] = wait_low_reg;
      end
      default: rd_next = `HLT_RST_DATA;
    endcase
  end

  // Data settles a cycle ahead of the committing edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= `HLT_RST_DATA;
    end else if (req && wait_reg) begin
      avs_readdata_o <= avs_read_i ? rd_next : `HLT_RST_DATA;
    end
  end

  // Software set beats a same-cycle hardware clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b0;
    end else if (wr_lane0 && idx == `HLT_IDX_CTRL) begin
      run_reg <= avs_writedata_i[`HLT_CTRL_RUN_BIT];
    end else if (clr_run) begin
      run_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg              <= `HLT_RST_MODE;
      period_value_reg      <= `HLT_RST_PERIOD;
      pulse_width_value_reg <= `HLT_RST_PULSE;
    end else if (wr_lane0) begin
      if (idx == `HLT_IDX_CTRL) begin
        mode_reg <= avs_writedata_i[`HLT_CTRL_MODE_MSB:`HLT_CTRL_MODE_LSB];
      end
      if (idx == `HLT_IDX_PERIOD) begin
        period_value_reg <= avs_writedata_i[7:0];
      end
      if (idx == `HLT_IDX_PULSE) begin
        pulse_width_value_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // Edge detection on synchronised copies only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ers_d_reg <= 1'b0;
      run_d_reg <= 1'b0;
    end else begin
      ers_d_reg <= ers_s;
      run_d_reg <= run_s;
    end
  end

  assign ers_rise  = ers_s & ~ers_d_reg;
  assign ers_fall  = ~ers_s & ers_d_reg;
  assign run_rise  = run_s & ~run_d_reg;
  assign per_match = (count_value_reg == period_value_reg);

  // Mode decode; unlisted codes behave as the plain gated timer
  always_comb begin
    cls      = CLS_FREE;
    edge_hit = 1'b0;
    lvl_act  = 1'b0;
    unique case (mode_reg)
      `HLT_MODE_EDGE_ANY: begin
        cls      = CLS_EDGE_HL;
        edge_hit = ers_rise | ers_fall;
      end
      `HLT_MODE_EDGE_RIS: begin
        cls      = CLS_EDGE_HL;
        edge_hit = ers_rise;
      end
      `HLT_MODE_EDGE_FAL: begin
        cls      = CLS_EDGE_HL;
        edge_hit = ers_fall;
      end
      `HLT_MODE_LVL_LOW: begin
        cls     = CLS_LEVEL_HL;
        lvl_act = ~ers_s;
      end
      `HLT_MODE_LVL_HIGH: begin
        cls     = CLS_LEVEL_HL;
        lvl_act = ers_s;
      end
      `HLT_MODE_OS_SW: cls = CLS_OS_SW;
      `HLT_MODE_OS_RIS: begin
        cls      = CLS_OS_EDGE;
        edge_hit = ers_rise;
      end
      `HLT_MODE_OS_FAL: begin
        cls      = CLS_OS_EDGE;
        edge_hit = ers_fall;
      end
      `HLT_MODE_OS_ANY: begin
        cls      = CLS_OS_EDGE;
        edge_hit = ers_rise | ers_fall;
      end
      default: cls = CLS_FREE;
    endcase
  end

  // Counter sequencing for every mode class
  always_comb begin
    count_value_next = count_value_reg;
    go_next          = go_reg;
    hold_next        = hold_reg;
    act_cnt_next     = act_cnt_reg;
    dly_next         = dly_reg;
    wait_low_next    = wait_low_reg & run_s;
    start            = 1'b0;
    clr_run          = 1'b0;
    if (!run_s) begin
      // Paused: count holds, external input ignored
      act_cnt_next = `HLT_DLY_ZERO;
      dly_next     = `HLT_DLY_ZERO;
      hold_next    = 1'b0;
      if (cls == CLS_OS_EDGE) begin
        go_next = 1'b0;
      end
    end else begin
      unique case (cls)
        CLS_EDGE_HL: begin
          if (edge_hit) begin
            count_value_next = `HLT_CNT_ZERO;
            dly_next         = `HLT_RST_DLY;
          end else if (dly_reg != `HLT_DLY_ZERO) begin
            count_value_next = `HLT_CNT_ZERO;
            dly_next         = dly_reg - `HLT_DLY_ONE;
            start            = (dly_reg == `HLT_DLY_ONE);
          end else if (per_match) begin
            count_value_next = `HLT_CNT_ZERO;
            start            = 1'b1;
          end else begin
            count_value_next = count_value_reg + `HLT_CNT_ONE;
            start            = run_rise;
          end
        end
        CLS_LEVEL_HL: begin
          if (lvl_act) begin
            dly_next = `HLT_DLY_ZERO;
            if (hold_reg) begin
              count_value_next = `HLT_CNT_ZERO;
            end else if (act_cnt_reg == `HLT_RST_DLY - `HLT_DLY_ONE) begin
              hold_next        = 1'b1;
              count_value_next = `HLT_CNT_ZERO;
            end else begin
              act_cnt_next     = act_cnt_reg + `HLT_DLY_ONE;
              count_value_next = per_match ? `HLT_CNT_ZERO
                                           : count_value_reg + `HLT_CNT_ONE;
              start            = per_match | run_rise;
            end
          end else begin
            act_cnt_next = `HLT_DLY_ZERO;
            if (hold_reg) begin
              // Held PWM is left alone until the pulse match
              count_value_next = `HLT_CNT_ZERO;
              if (dly_reg == `HLT_RST_DLY - `HLT_DLY_ONE) begin
                hold_next = 1'b0;
                dly_next  = `HLT_DLY_ZERO;
                start     = 1'b1;
              end else begin
                dly_next = dly_reg + `HLT_DLY_ONE;
              end
            end else if (per_match) begin
              count_value_next = `HLT_CNT_ZERO;
              start            = 1'b1;
            end else begin
              count_value_next = count_value_reg + `HLT_CNT_ONE;
              start            = run_rise;
            end
          end
        end
        CLS_OS_SW: begin
          // Waiting for the cleared run bit to be seen low
          if (wait_low_reg) begin
            count_value_next = `HLT_CNT_ZERO;
          end else if (!go_reg) begin
            go_next = 1'b1;
            start   = 1'b1;
          end else if (per_match) begin
            count_value_next = `HLT_CNT_ZERO;
            go_next          = 1'b0;
            clr_run          = 1'b1;
            wait_low_next    = 1'b1;
          end else begin
            count_value_next = count_value_reg + `HLT_CNT_ONE;
          end
        end
        CLS_OS_EDGE: begin
          if (wait_low_reg) begin
            count_value_next = `HLT_CNT_ZERO;
          end else if (!go_reg) begin
            if (edge_hit) begin
              go_next = 1'b1;
              start   = (count_value_reg == `HLT_CNT_ZERO);
            end
          end else if (per_match) begin
            count_value_next = `HLT_CNT_ZERO;
            go_next          = 1'b0;
            clr_run          = 1'b1;
            wait_low_next    = 1'b1;
          end else begin
            count_value_next = count_value_reg + `HLT_CNT_ONE;
          end
        end
        CLS_FREE: begin
          if (per_match) begin
            count_value_next = `HLT_CNT_ZERO;
            start            = 1'b1;
          end else begin
            count_value_next = count_value_reg + `HLT_CNT_ONE;
            start            = run_rise;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_value_reg <= `HLT_RST_COUNT;
    end else begin
      count_value_reg <= count_value_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_reg       <= 1'b0;
      wait_low_reg <= 1'b0;
    end else begin
      go_reg       <= go_next;
      wait_low_reg <= wait_low_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg    <= 1'b0;
      act_cnt_reg <= `HLT_DLY_ZERO;
      dly_reg     <= `HLT_DLY_ZERO;
    end else begin
      hold_reg    <= hold_next;
      act_cnt_reg <= act_cnt_next;
      dly_reg     <= dly_next;
    end
  end

endmodule

// *** hlt_timer_checker.sv ***
module hlt_timer_checker (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        external_reset_input_i,
  input wire logic        pwm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] per_reg;
  logic [7:0] pul_reg;
  logic [7:0] ctl_reg;
  logic [3:0] hi_cnt;
  logic       req;
  logic       done;
  logic [2:0] idx;
  assign req  = avs_read_i | avs_write_i;
  assign done = req & ~avs_waitrequest_o;
  assign idx  = avs_address_i[4:2];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_reg <= 8'hFF;
      pul_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end else if (done && avs_write_i && avs_byteenable_i[0]) begin
      if (idx == 3'h0) ctl_reg <= avs_writedata_i[7:0];
      if (idx == 3'h1) per_reg <= avs_writedata_i[7:0];
      if (idx == 3'h2) pul_reg <= avs_writedata_i[7:0];
    end
  end
  // Saturates so a long hold never wraps back under the bound
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      hi_cnt <= 4'h0;
    else if (!(ctl_reg == 8'h87 && external_reset_input_i))
      hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF)
      hi_cnt <= hi_cnt + 4'h1;
  end
  sequence seen_s;
    req && avs_waitrequest_o;
  endsequence
  sequence rd_ans(logic [2:0] i);
    done && avs_read_i && idx == i;
  endsequence
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  answer_a: assert property (seen_s |=> !avs_waitrequest_o)
    else $error("access not answered on the next edge");
  no_spurious_a: assert property (!avs_waitrequest_o |-> $past(req))
    else $error("waitrequest low without a request");
  upper_zero_a: assert property (done |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  unmapped_a: assert property
    (done && avs_read_i && idx > 3'h4 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!req |=> $stable(avs_readdata_o))
    else $error("read data changed without an access");
  period_back_a: assert property
    (rd_ans(3'h1) |-> avs_readdata_o[7:0] == per_reg)
    else $error("period readback mismatch");
  pulse_back_a: assert property
    (rd_ans(3'h2) |-> avs_readdata_o[7:0] == pul_reg)
    else $error("pulse width readback mismatch");
  level_hold_a: assert property
    (rd_ans(3'h3) ##0 hi_cnt > 4'hB |-> avs_readdata_o == 32'h0)
    else $error("count not held during reset level");
endmodule
bind hlt_timer hlt_timer_checker chk_u (.*);

// *** hw_limit_oneshot_timer_test.sv ***
`include "hlt_consts.svh"
module hw_limit_oneshot_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0;
  logic        rst_n_i = 0;
  logic [4:0]  adr = 0;
  logic        rd = 0;
  logic        wr = 0;
  logic [31:0] wd = 0;
  logic [3:0]  be = 0;
  logic [31:0] rdata;
  logic        wreq;
  logic        ers_want = 0;
  logic        ers;
  logic        pwm;
  logic [31:0] got;
  logic [31:0] c1;
  logic [4:0]  em [3] = '{`HLT_MODE_EDGE_RIS, `HLT_MODE_EDGE_FAL,
                           `HLT_MODE_EDGE_ANY};
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #5 mclk_i = ~mclk_i;
  hlt_ers_model ers_u (.mclk_i(mclk_i), .want_i(ers_want), .ers_o(ers));
  hlt_timer dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .external_reset_input_i(ers), .pwm_o(pwm));
  task automatic conclude;
    $display("fails %0d checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(logic w, logic [2:0] i, logic [7:0] d, logic [3:0] b);
    adr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    be <= b;
    @(posedge mclk_i);
    while (wreq !== 1'b0) @(posedge mclk_i);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wrt(logic [2:0] i, logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask
  task automatic rdc(string n, logic [2:0] i, logic [31:0] e);
    bus(1'b0, i, 8'h00, 4'hF);
    chk(n, e, got);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic waitpwm;
    int k;
    k = 0;
    while (pwm !== 1'b1 && k < 14) begin
      @(posedge mclk_i);
      k++;
    end
    chk("pwm rise", 1, pwm);
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    tick(4);
    rst_n_i <= 1'b1;
    tick(1);
    rdc("ctrl", 0, 0);
    rdc("period", 1, 8'hFF);
    rdc("pulse", 2, 0);
    rdc("count", 3, 0);
    rdc("unmapped", 7, 0);
    wrt(3, 8'h55);
    bus(1'b1, 1, 8'h33, 4'h0);
    rdc("count ro", 3, 0);
    rdc("period be", 1, 8'hFF);
    $display("test registers done");
    wrt(1, 8'h05);
    wrt(2, 8'h02);
    wrt(0, 8'h88);
    waitpwm();
    tick(20);
    rdc("os ctrl", 0, 8'h08);
    rdc("os count", 3, 0);
    chk("os pwm", 0, pwm);
    $display("test sw one-shot done");
    wrt(0, 8'h89);
    tick(20);
    rdc("eos idle", 3, 0);
    ers_want <= 1'b1;
    waitpwm();
    tick(20);
    rdc("eos ctrl", 0, 8'h09);
    chk("eos pwm", 0, pwm);
    $display("test edge one-shot done");
    // Long period so a pause lands before the pulse match
    wrt(1, 8'h40);
    wrt(2, 8'h20);
    wrt(0, 8'h88);
    waitpwm();
    wrt(0, 8'h08);
    tick(40);
    chk("os stretch", 1, pwm);
    wrt(0, 8'h88);
    tick(100);
    rdc("os resume", 0, 8'h08);
    chk("os pwm off", 0, pwm);
    wrt(0, 8'h89);
    ers_want <= 1'b0;
    tick(4);
    ers_want <= 1'b1;
    waitpwm();
    wrt(0, 8'h09);
    wrt(0, 8'h89);
    tick(5);
    bus(1'b0, 3, 8'h00, 4'hF);
    c1 = got;
    tick(10);
    rdc("eos wait", 3, c1);
    ers_want <= 1'b0;
    tick(4);
    ers_want <= 1'b1;
    tick(100);
    rdc("eos resume", 0, 8'h09);
    chk("eos pwm off", 0, pwm);
    $display("test one-shot pause done");
    wrt(1, 8'hFF);
    wrt(2, 8'h20);
    ers_want <= 1'b0;
    foreach (em[j]) begin
      wrt(0, {3'b100, em[j]});
      tick(50);
      chk("pwm early", 0, pwm);
      ers_want <= ~ers_want;
      waitpwm();
      rdc("limit count", 3, 1);
      chk("count cleared", 1, got < 8);
    end
    $display("test edge limit done");
    ers_want <= 1'b1;
    wrt(0, 8'h87);
    tick(20);
    rdc("level hold", 3, 0);
    ers_want <= 1'b0;
    tick(10);
    chk("level resume", 1, pwm);
    wrt(0, 8'h07);
    tick(5);
    rdc("stopped", 3, 9);
    c1 = got;
    ers_want <= 1'b1;
    tick(10);
    rdc("frozen", 3, c1);
    wrt(0, 8'h86);
    ers_want <= 1'b0;
    tick(20);
    rdc("low hold", 3, 0);
    $display("test level limit done");
    conclude();
  end
endmodule
